// ---- host_port_model.sv ----
/* Host model driving the register byte port of the light sensor bank.
   Assumes a bench that calls its tasks and shares its clock. */
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
	// Clock.
	input  wire logic       clk,
	// Byte port towards the bank.
	output var  logic [4:0] reg_addr,
	output var  logic       reg_wr,
	output var  logic [7:0] reg_wdata,
	output var  logic       reg_rd,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	initial begin
		reg_addr = 5'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end

	// Callers keep reserved bits zero and low gain off above 8x.
	task automatic put(input logic [4:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
		reg_addr = ~a;
	endtask

	// A two-byte read keeps the low and high bytes of one result paired.
	task automatic get(input logic [4:0] a, input logic two,
		output logic [7:0] lo, output logic [7:0] hi);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_addr = a + 5'h01;
		reg_rd = two;
		lo = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_addr = ~reg_addr;
		hi = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
	endtask
endmodule
`default_nettype wire

// ---- light_regs_pkg.sv ----
/*
 * Constants, field layouts, timing counts and carrier types for the light
 * sensor configuration and status register bank.
 * Assumes a single 250 MHz clock and a register port driven by the serial
 * bus slave logic on that same clock.
 */
// Notes on behaviour
// R1 - Host writes zero to reserved configuration bits 7:3, 0 and control 7:2.
// R2 - Low-gain scale bit set scales 1x and 8x gains by 0.16.
// R3 - Host never sets low-gain scale while gain select is above 8x.
// R4 - Wait-extend bit makes every wait step twelve times longer.
// R5 - Gain select 00, 01, 10, 11 give 1x, 8x, 16x, 120x.
// R6 - Identifier register reads a fixed 8-bit part code.
// R7 - Status register is read-only; host writes leave it alone.
// R8 - Status bits 7:5 and 3:1 always read zero.
// R9 - Status bit 4 reads one while the light interrupt is asserted.
// R10 - Status bit 0 sets once both channels finish integration after enable.
// R11 - Results are held as two 16-bit words, channel 0 and channel 1.
// R12 - Result bytes sit at 0x14, 0x15, 0x16 and 0x17.
// R13 - Reading a low byte copies its high byte into a shadow register.
// R14 - High byte read returns the value paired with the earlier low byte.
// R15 - Host fetches each result with one two-byte auto-increment read; the bench reads channel 1 with two one-byte reads.
// R16 - Wait step lasts 2.73 ms; count is two's complement, 0xFF is one step.
// R17 - Interrupt when channel 0 leaves threshold window, after persistence.
// R18 - Writes to identifier, status and result registers change nothing.
package light_regs_pkg;

	localparam logic [4:0] ADDR_CONFIG   = 5'h0D;
	localparam logic [4:0] ADDR_CONTROL  = 5'h0F;
	localparam logic [4:0] ADDR_PART_ID  = 5'h12;
	localparam logic [4:0] ADDR_STATUS   = 5'h13;
	localparam logic [4:0] ADDR_CH0_LOW  = 5'h14;
	localparam logic [4:0] ADDR_CH0_HIGH = 5'h15;
	localparam logic [4:0] ADDR_CH1_LOW  = 5'h16;
	localparam logic [4:0] ADDR_CH1_HIGH = 5'h17;

	localparam int CFG_LOW_GAIN_BIT    = 2;
	localparam int CFG_WAIT_EXT_BIT    = 1;
	localparam int STAT_IRQ_BIT        = 4;
	localparam int STAT_VALID_BIT      = 0;

	localparam logic [7:0] CONFIG_RESET  = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO     = 8'h00;
	// Part code value is arbitrary.
	localparam logic [7:0] PART_CODE_DEFAULT = 8'h5A;

	localparam logic [1:0] GAIN_1X   = 2'h0;
	localparam logic [1:0] GAIN_8X   = 2'h1;
	localparam logic [1:0] GAIN_16X  = 2'h2;
	localparam logic [1:0] GAIN_120X = 2'h3;

	// Effective gain in hundredths of unity gain.
	localparam logic [13:0] GAIN_1X_HUND        = 14'h0064;
	localparam logic [13:0] GAIN_8X_HUND        = 14'h0320;
	localparam logic [13:0] GAIN_16X_HUND       = 14'h0640;
	localparam logic [13:0] GAIN_120X_HUND      = 14'h2EE0;
	localparam logic [13:0] GAIN_1X_SCALED_HUND = 14'h0010;
	localparam logic [13:0] GAIN_8X_SCALED_HUND = 14'h0080;

	localparam int CLK_PERIOD_NS   = 4;
	localparam int WAIT_STEP_NS    = 2730000;
	localparam int WAIT_STEP_CYCLES = WAIT_STEP_NS / CLK_PERIOD_NS;
	localparam logic [3:0] WAIT_EXTEND_FACTOR = 4'hC;
	localparam logic [8:0] WAIT_STEPS_FULL = 9'h100;

	typedef struct packed {
		logic [15:0] ch1;
		logic [15:0] ch0;
	} result_pair_t;

	typedef struct packed {
		logic [15:0] high;
		logic [15:0] low;
	} threshold_pair_t;

	// Consecutive out-of-range results needed for each persistence code.
	function automatic logic [5:0] persist_needed(input logic [3:0] code);
		logic [5:0] n;
		n = 6'h00;
		case (code)
			4'h0: n = 6'h00;
			4'h1: n = 6'h01;
			4'h2: n = 6'h02;
			4'h3: n = 6'h03;
			4'h4: n = 6'h05;
			default: n = 6'(({2'h0, code} - 6'h03) * 6'h05);
		endcase
		return n;
	endfunction

endpackage

// ---- light_sensor_config_status_regs.sv ----
/*
 * Register bank for the configuration, gain, identifier, status and
 * result bytes of the light sensor, plus the wait timer and the light
 * interrupt decision that those bits steer.
 * Assumes the serial bus slave presents decoded byte reads and writes on
 * clk, and that the measurement core delivers results on clk as well.
 */
`timescale 1ns/1ps
`default_nettype none

module light_sensor_config_status_regs
	import light_regs_pkg::*;
#(
	parameter int          WAIT_STEP_CYC = WAIT_STEP_CYCLES,
	parameter logic [7:0]  PART_CODE     = PART_CODE_DEFAULT
) (
	// Clock, reset and clock enable.
	input  wire logic            clk,
	input  wire logic            reset,
	input  wire logic            ce,
	// Register port from the serial bus slave.
	input  wire logic [4:0]      reg_addr,
	input  wire logic            reg_wr,
	input  wire logic [7:0]      reg_wdata,
	input  wire logic            reg_rd,
	output logic      [7:0]      reg_rdata,
	output logic                 reg_rvalid,
	// Measurement core and neighbouring registers.
	input  wire logic            light_sense_enable,
	input  wire logic            result_done,
	input  wire result_pair_t    result_in,
	input  wire threshold_pair_t thresholds,
	input  wire logic [3:0]      persist_code,
	input  wire logic            irq_clear,
	// Wait timer.
	input  wire logic            wait_start,
	input  wire logic [7:0]      wait_count,
	output logic                 wait_active,
	output logic                 wait_done,
	// Analog gain and interrupt outputs.
	output logic      [1:0]      gain_select,
	output logic                 low_gain_scale,
	output logic      [13:0]     gain_hundredths,
	output logic                 light_irq
);

	logic [7:0]   config_r;
	logic [7:0]   control_r;
	result_pair_t result_r;
	logic [7:0]   ch0_shadow_r;
	logic [7:0]   ch1_shadow_r;
	logic         irq_r;
	logic         valid_r;
	logic [7:0]   rdata_r;
	logic         rvalid_r;
	logic [5:0]   persist_cnt_r;
	logic [5:0]   persist_cnt_nxt;
	logic [13:0]  gain_r;
	logic [13:0]  gain_nxt;

	// Write decode: only the two writable registers respond.
	wire logic wr_config  = ce & reg_wr & (reg_addr == ADDR_CONFIG);
	wire logic wr_control = ce & reg_wr & (reg_addr == ADDR_CONTROL);
	wire logic rd_fire    = ce & reg_rd;
	wire logic rd_ch0_low = rd_fire & (reg_addr == ADDR_CH0_LOW);
	wire logic rd_ch1_low = rd_fire & (reg_addr == ADDR_CH1_LOW);

	// Only the defined bits are stored, so reserved bits read as zero.
	wire logic [7:0] config_mask  = 8'h06; // see R1
	wire logic [7:0] control_mask = 8'h03; // see R1
	wire logic       cfg_low_gain = config_r[CFG_LOW_GAIN_BIT];
	wire logic       cfg_wait_ext = config_r[CFG_WAIT_EXT_BIT];
	wire logic [1:0] gain_code    = control_r[1:0];

	wire logic [7:0] status_byte = {3'h0, irq_r, 3'h0, valid_r}; // see R8

	// Read multiplexer; unmapped addresses return zero.
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = READ_ZERO;
		case (reg_addr)
			ADDR_CONFIG:   rd_mux = config_r;
			ADDR_CONTROL:  rd_mux = control_r;
			ADDR_PART_ID:  rd_mux = PART_CODE;       // see R6
			ADDR_STATUS:   rd_mux = status_byte;     // see R9
			ADDR_CH0_LOW:  rd_mux = result_r.ch0[7:0];  // see R12
			ADDR_CH0_HIGH: rd_mux = ch0_shadow_r;    // see R13
			ADDR_CH1_LOW:  rd_mux = result_r.ch1[7:0];  // see R12
			ADDR_CH1_HIGH: rd_mux = ch1_shadow_r;    // see R13
			default:       rd_mux = READ_ZERO;
		endcase
	end

	// Effective analog gain, with the 0.16 scale on the two low settings.
	always_comb begin
		gain_nxt = GAIN_1X_HUND;
		unique case (gain_code) // see R5
			GAIN_1X:   gain_nxt = cfg_low_gain ? GAIN_1X_SCALED_HUND
			                                   : GAIN_1X_HUND; // see R2
			GAIN_8X:   gain_nxt = cfg_low_gain ? GAIN_8X_SCALED_HUND
			                                   : GAIN_8X_HUND; // see R2
			GAIN_16X:  gain_nxt = GAIN_16X_HUND;
			GAIN_120X: gain_nxt = GAIN_120X_HUND;
		endcase
	end

	// Configuration and control registers.
	always_ff @(posedge clk) begin
		if (reset) begin
			config_r  <= CONFIG_RESET;
			control_r <= CONTROL_RESET;
		end else begin
			if (wr_config) begin
				config_r <= reg_wdata & config_mask;
			end
			if (wr_control) begin
				control_r <= reg_wdata & control_mask;
			end
		end
	end

	// Results are caught whole, so both bytes of a word always belong
	// together.
	always_ff @(posedge clk) begin
		if (reset) begin
			result_r <= '0;
		end else if (ce & result_done) begin
			result_r <= result_in; // see R11
		end
	end

	// The shadow copy is taken in the same cycle as the low byte is read,
	// which keeps the pair intact across later results.
	always_ff @(posedge clk) begin
		if (reset) begin
			ch0_shadow_r <= READ_ZERO;
		end else if (rd_ch0_low) begin
			ch0_shadow_r <= result_r.ch0[15:8]; // see R13, R14
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ch1_shadow_r <= READ_ZERO;
		end else if (rd_ch1_low) begin
			ch1_shadow_r <= result_r.ch1[15:8]; // see R13, R14
		end
	end

	// Read data is registered; writes never reach these stores.
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_r  <= READ_ZERO;
			rvalid_r <= 1'b0;
		end else if (ce) begin
			rvalid_r <= reg_rd;
			if (reg_rd) begin
				rdata_r <= rd_mux; // see R7, R18
			end
		end
	end

	// Valid flag: first completed integration after enable sets it, and
	// dropping the enable clears it.
	always_ff @(posedge clk) begin
		if (reset) begin
			valid_r <= 1'b0;
		end else if (ce) begin
			if (!light_sense_enable) begin
				valid_r <= 1'b0;
			end else if (result_done) begin
				valid_r <= 1'b1; // see R10
			end
		end
	end

	// Persistence filter on channel 0 against the threshold window.
	wire logic out_of_range = (result_in.ch0 < thresholds.low) |
	                          (result_in.ch0 > thresholds.high);
	wire logic [5:0] need = persist_needed(persist_code);
	always_comb begin
		persist_cnt_nxt = persist_cnt_r;
		if (result_done) begin
			if (!out_of_range) begin
				persist_cnt_nxt = 6'h00;
			end else if (persist_cnt_r != 6'h3F) begin
				persist_cnt_nxt = persist_cnt_r + 6'h01;
			end
		end
	end
	wire logic irq_event = ce & light_sense_enable & result_done &
	                       ((need == 6'h00) | (out_of_range &
	                        (persist_cnt_nxt >= need))); // see R17

	// The out-of-range run restarts whenever sensing is switched off.
	always_ff @(posedge clk) begin
		if (reset) begin
			persist_cnt_r <= 6'h00;
		end else if (ce) begin
			persist_cnt_r <= light_sense_enable ? persist_cnt_nxt : 6'h00;
		end
	end

	// A new event in the clearing cycle keeps the flag set.
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_r <= 1'b0;
		end else if (irq_event) begin
			irq_r <= 1'b1; // see R9
		end else if (ce & irq_clear) begin
			irq_r <= 1'b0;
		end
	end

	// Wait timer: steps are 256 minus the count, each step one base
	// period, or twelve base periods when extended.
	logic [31:0] cyc_cnt_r;
	logic [3:0]  sub_cnt_r;
	logic [8:0]  step_cnt_r;
	logic        wait_act_r;
	logic        wait_done_r;
	wire logic [8:0] steps_total = WAIT_STEPS_FULL - {1'b0, wait_count};
	wire logic [3:0] sub_total   = cfg_wait_ext ? WAIT_EXTEND_FACTOR
	                                            : 4'h1; // see R4
	wire logic cyc_end  = (cyc_cnt_r == 32'(WAIT_STEP_CYC - 1)); // see R16
	wire logic sub_end  = cyc_end & (sub_cnt_r == sub_total - 4'h1);
	wire logic step_end = sub_end & (step_cnt_r == 9'h001);

	wire logic wait_load = ~wait_act_r & wait_start;
	wire logic step_last = wait_act_r & step_end;
	wire logic step_next = wait_act_r & sub_end & ~step_end;

	// The counters rest on their end values after a wait ends, so the finish
	// pulse is qualified by the run flag.
	always_ff @(posedge clk) begin
		if (reset) begin
			wait_act_r  <= 1'b0;
			wait_done_r <= 1'b0;
		end else if (ce) begin
			wait_done_r <= step_last;
			if (wait_load) begin
				wait_act_r <= 1'b1;
			end else if (step_last) begin
				wait_act_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cyc_cnt_r <= 32'h0;
		end else if (ce) begin
			if (wait_load | (wait_act_r & cyc_end & ~step_end)) begin
				cyc_cnt_r <= 32'h0;
			end else if (wait_act_r & ~cyc_end) begin
				cyc_cnt_r <= cyc_cnt_r + 32'h1;
			end
		end
	end

	// Base periods within one step: one, or twelve when extended.
	always_ff @(posedge clk) begin
		if (reset) begin
			sub_cnt_r <= 4'h0;
		end else if (ce) begin
			if (wait_load | step_next) begin
				sub_cnt_r <= 4'h0;
			end else if (wait_act_r & cyc_end & ~sub_end) begin
				sub_cnt_r <= sub_cnt_r + 4'h1;
			end
		end
	end

	// Steps still to run are loaded from the two's complement count.
	always_ff @(posedge clk) begin
		if (reset) begin
			step_cnt_r <= 9'h000;
		end else if (ce) begin
			if (wait_load) begin
				step_cnt_r <= steps_total; // see R16
			end else if (step_next) begin
				step_cnt_r <= step_cnt_r - 9'h001;
			end
		end
	end

	// The gain value output is a registered copy of the decoded setting.
	always_ff @(posedge clk) begin
		if (reset) begin
			gain_r <= GAIN_1X_HUND;
		end else if (ce) begin
			gain_r <= gain_nxt;
		end
	end

	assign reg_rdata       = rdata_r;
	assign reg_rvalid      = rvalid_r;
	assign wait_active     = wait_act_r;
	assign wait_done       = wait_done_r;
	assign gain_select     = control_r[1:0];
	assign low_gain_scale  = config_r[CFG_LOW_GAIN_BIT];
	assign gain_hundredths = gain_r;
	assign light_irq       = irq_r;

endmodule

`default_nettype wire

// ---- light_sensor_config_status_regs_chk.sv ----
/* Assertions on the ports of the light sensor register bank.
   Assumes one clock and a synchronous active high reset. */
`timescale 1ns/1ps
`default_nettype none
module light_sensor_config_status_regs_chk
	import light_regs_pkg::*;
#(
	parameter int         WAIT_STEP_CYC = WAIT_STEP_CYCLES,
	parameter logic [7:0] PART_CODE     = PART_CODE_DEFAULT
) (
	// Clock and control.
	input wire logic clk, reset, ce,
	// Register port.
	input wire logic [4:0] reg_addr,
	input wire logic reg_wr, reg_rd, reg_rvalid,
	input wire logic [7:0] reg_wdata, reg_rdata,
	// Core side.
	input wire logic light_sense_enable, result_done, irq_clear,
	input wire result_pair_t result_in,
	input wire threshold_pair_t thresholds,
	input wire logic [3:0] persist_code,
	input wire logic wait_start, wait_active, wait_done, low_gain_scale,
	input wire logic [7:0] wait_count,
	input wire logic [1:0] gain_select,
	input wire logic [13:0] gain_hundredths,
	input wire logic light_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	wire rd_ok = ce && reg_rd;
	wire wr_ok = ce && reg_wr;

	a_id_read: assert property (
		rd_ok && reg_addr == ADDR_PART_ID |=> reg_rvalid && reg_rdata == PART_CODE)
		else $error("part code read wrong");
	a_status_zeros: assert property (
		rd_ok && reg_addr == ADDR_STATUS |=> (reg_rdata & 8'hEE) == 8'h00)
		else $error("reserved status bits not zero");
	a_status_irq: assert property (
		rd_ok && reg_addr == ADDR_STATUS && !irq_clear && !result_done
		|=> reg_rdata[STAT_IRQ_BIT] == $past(light_irq))
		else $error("status irq bit differs from irq");
	a_rvalid_cause: assert property (
		$past(ce) |-> reg_rvalid == $past(reg_rd))
		else $error("read answer does not follow read");
	a_status_ro: assert property (
		wr_ok && reg_addr == ADDR_STATUS && !result_done && !irq_clear
		|=> $stable(light_irq))
		else $error("status write changed irq");
	a_ctrl_write: assert property (
		wr_ok && reg_addr == ADDR_CONTROL
		|=> {6'h00, gain_select} == ($past(reg_wdata) & 8'h03))
		else $error("gain select not written");
	a_gain_table: assert property (
		$stable(gain_select) && $stable(low_gain_scale) && !low_gain_scale
		|-> gain_hundredths == (gain_select == GAIN_1X ? GAIN_1X_HUND :
		gain_select == GAIN_8X ? GAIN_8X_HUND :
		gain_select == GAIN_16X ? GAIN_16X_HUND : GAIN_120X_HUND))
		else $error("gain value wrong");
	a_gain_scaled: assert property (
		$stable(gain_select) && $stable(low_gain_scale) && low_gain_scale
		&& gain_select[1] == 1'b0 |-> gain_hundredths ==
		(gain_select == GAIN_1X ? GAIN_1X_SCALED_HUND : GAIN_8X_SCALED_HUND))
		else $error("scaled gain wrong");
	a_irq_holds: assert property (
		light_irq && !irq_clear |=> light_irq)
		else $error("irq dropped without clear");
	a_wait_done: assert property (
		wait_done |-> !wait_active && $past(wait_active))
		else $error("wait done without running timer");
	cover property (rd_ok && reg_addr == ADDR_CH0_HIGH);
	cover property ($rose(light_irq));
	cover property (wait_done);
endmodule

bind light_sensor_config_status_regs light_sensor_config_status_regs_chk
	#(.WAIT_STEP_CYC(WAIT_STEP_CYC), .PART_CODE(PART_CODE))
	i_light_sensor_config_status_regs_chk (.*);
`default_nettype wire

// ---- test_light_sensor_config_status_regs.sv ----
/* Self-checking bench of the light sensor register bank.
   Assumes the package, the host model and the checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
module test_light_sensor_config_status_regs;
	import light_regs_pkg::*;
	localparam int STEP = 3;
	// Part code value is arbitrary.
	localparam logic [7:0] PCODE = 8'hC3;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic [4:0] reg_addr;
	logic reg_wr, reg_rd, reg_rvalid;
	logic [7:0] reg_wdata, reg_rdata;
	logic light_sense_enable = 1'b0;
	logic result_done = 1'b0;
	result_pair_t result_in = '0;
	threshold_pair_t thresholds = '0;
	logic [3:0] persist_code = 4'h1;
	logic irq_clear = 1'b0;
	logic wait_start = 1'b0;
	logic [7:0] wait_count = 8'hFF;
	logic wait_active, wait_done, low_gain_scale, light_irq;
	logic [1:0] gain_select;
	logic [13:0] gain_hundredths;
	int fail_count = 0;
	int comparisons = 0;

	light_sensor_config_status_regs #(.WAIT_STEP_CYC(STEP), .PART_CODE(PCODE))
		i_light_sensor_config_status_regs (.*);
	host_port_model i_host_port_model (.*);

	initial forever #2 clk = ~clk;

	task automatic close_out;
		$display("checks %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic rd1(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] lo, hi;
		i_host_port_model.get(a, 1'b0, lo, hi);
		chk(lo, e);
	endtask

	task automatic strobe_done;
		@(negedge clk);
		result_done = 1'b1;
		@(negedge clk);
		result_done = 1'b0;
	endtask

	task automatic clear_irq;
		@(negedge clk);
		irq_clear = 1'b1;
		@(negedge clk);
		irq_clear = 1'b0;
	endtask

	task automatic reset_vals;
		chk(gain_hundredths, GAIN_1X_HUND);
		rd1(ADDR_CONFIG, 8'h00);
		rd1(ADDR_PART_ID, PCODE);
		rd1(ADDR_STATUS, 8'h00);
		rd1(ADDR_CH0_HIGH, 8'h00);
		i_host_port_model.put(5'h1E, 8'h5A);
		rd1(5'h1F, 8'h00);
	endtask

	task automatic gains;
		logic [13:0] tab [4];
		tab = '{GAIN_1X_HUND, GAIN_8X_HUND, GAIN_16X_HUND, GAIN_120X_HUND};
		for (int g = 0; g < 4; g++) begin
			i_host_port_model.put(ADDR_CONTROL, 8'(g));
			@(negedge clk);
			chk(gain_hundredths, tab[g]);
			rd1(ADDR_CONTROL, 8'(g));
		end
		i_host_port_model.put(ADDR_CONTROL, 8'h00);
		i_host_port_model.put(ADDR_CONFIG, 8'h04);
		@(negedge clk);
		chk(gain_hundredths, GAIN_1X_SCALED_HUND);
		i_host_port_model.put(ADDR_CONTROL, 8'h01);
		@(negedge clk);
		chk(gain_hundredths, GAIN_8X_SCALED_HUND);
		i_host_port_model.put(ADDR_CONFIG, 8'h02);
		@(negedge clk);
		chk(gain_hundredths, GAIN_8X_HUND);
		rd1(ADDR_CONFIG, 8'h02);
	endtask

	task automatic results;
		logic [7:0] lo, hi;
		thresholds = '{high: 16'h2000, low: 16'h1000};
		result_in = '{ch1: 16'hA1B2, ch0: 16'h1234};
		light_sense_enable = 1'b1;
		strobe_done();
		chk(light_irq, 1'b0);
		rd1(ADDR_STATUS, 8'h01);
		i_host_port_model.get(ADDR_CH0_LOW, 1'b1, lo, hi);
		chk({hi, lo}, 16'h1234);
		rd1(ADDR_CH1_LOW, 8'hB2);
		// A newer result lands between the low and high reads.
		result_in = '{ch1: 16'h5678, ch0: 16'h0123};
		strobe_done();
		chk(light_irq, 1'b1);
		rd1(ADDR_CH1_HIGH, 8'hA1);
		rd1(ADDR_STATUS, 8'h11);
		clear_irq();
		rd1(ADDR_STATUS, 8'h01);
		light_sense_enable = 1'b0;
		rd1(ADDR_STATUS, 8'h00);
	endtask

	task automatic ro_writes;
		for (int a = 18; a < 24; a++) i_host_port_model.put(5'(a), 8'hFF);
		rd1(ADDR_CH0_HIGH, 8'h12);
		rd1(ADDR_PART_ID, PCODE);
		rd1(ADDR_STATUS, 8'h00);
		rd1(ADDR_CH0_LOW, 8'h23);
		rd1(ADDR_CH0_HIGH, 8'h01);
	endtask

	// Nothing moves while the clock enable is low.
	task automatic freeze;
		@(negedge clk);
		ce = 1'b0;
		i_host_port_model.put(ADDR_CONTROL, 8'h03);
		result_in = '{ch1: 16'hFFFF, ch0: 16'hFFFF};
		strobe_done();
		ce = 1'b1;
		chk(gain_select, 16'h0001);
		rd1(ADDR_CONTROL, 8'h01);
		rd1(ADDR_CH0_LOW, 8'h23);
	endtask

	task automatic persistence;
		result_in = '{ch1: 16'h0000, ch0: 16'h3000};
		persist_code = 4'h5;
		light_sense_enable = 1'b1;
		for (int k = 1; k <= 10; k++) begin
			strobe_done();
			chk(light_irq, 16'(k == 10));
		end
		// An event in the clearing cycle wins over the clear.
		persist_code = 4'h0;
		result_in.ch0 = 16'h1800;
		@(negedge clk);
		irq_clear = 1'b1;
		result_done = 1'b1;
		@(negedge clk);
		irq_clear = 1'b0;
		result_done = 1'b0;
		chk(light_irq, 1'b1);
		clear_irq();
		chk(light_irq, 1'b0);
		light_sense_enable = 1'b0;
	endtask

	task automatic waits;
		int n;
		for (int x = 0; x < 2; x++) begin
			i_host_port_model.put(ADDR_CONFIG, x ? 8'h02 : 8'h00);
			wait_count = x ? 8'hFE : 8'hFF;
			@(negedge clk);
			wait_start = 1'b1;
			@(negedge clk);
			wait_start = 1'b0;
			chk(wait_active, 1'b1);
			n = 1;
			while (wait_done !== 1'b1 && n < 200) begin
				@(negedge clk);
				n++;
			end
			chk(16'(n), 16'(x ? 24 * STEP + 1 : STEP + 1));
			if (n >= 200) close_out();
		end
	endtask

	initial begin
		repeat (8) @(negedge clk);
		reset = 1'b0;
		reset_vals();
		gains();
		results();
		ro_writes();
		freeze();
		persistence();
		waits();
		close_out();
	end
endmodule
`default_nettype wire
